// ---- verilog/caa_alarm_aggregator.sv ----
// sticky alarm collector with mask, summary bit, status pin and register port
`timescale 1ns/1ps
`default_nettype none
`include "caa_defines.svh"
module caa_alarm_aggregator
  import caa_pkg::*;
#(
  parameter int LANES = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             soft_reset,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire caa_addr_t        reg_addr,
  input  wire caa_byte_t        reg_wdata,
  output caa_byte_t             reg_rdata,
  output logic                  reg_rvalid,
  input  wire logic [LANES-1:0] lane_fifo_err,
  input  wire logic             pll_locked,
  input  wire logic             link_enable,
  input  wire logic             link_mode_64b66b,
  input  wire logic             link_in_data_state,
  input  wire logic             link_startup,
  input  wire logic             link_realign,
  input  wire logic             sysref_realign,
  input  wire logic             osc_sync,
  input  wire logic             osc_phase_mismatch,
  input  wire logic             divider_mismatch,
  input  wire logic             alarm_pin_sel,
  input  wire logic             cal_status,
  output logic                  calibration_status_pin
);
  logic [`CAA_NUM_FLAGS-1:0] alarm_flag_status;
  logic [LANES-1:0]          per_lane_overflow_alarm;
  logic [1:0]                status_rsvd_q;
  caa_byte_t                 alarm_flag_mask_q;
  caa_byte_t                 rdata_q;
  logic                      rvalid_q;
  logic                      pin_q;

  // address decode
  wire hit_status  = reg_addr == `CAA_OFS_STATUS;
  wire hit_mask    = reg_addr == `CAA_OFS_MASK;
  wire hit_lane_lo = reg_addr == `CAA_OFS_LANE_LO;
  wire hit_lane_hi = reg_addr == `CAA_OFS_LANE_HI;
  wire hit_summary = reg_addr == `CAA_OFS_SUMMARY;
  wire wr_status   = reg_wr & hit_status;
  wire wr_mask     = reg_wr & hit_mask;

  // alarm causes
  wire lane_fifo_alarm        = |lane_fifo_err;
  wire pll_lock_alarm         = ~pll_locked;
  wire link_8b10b_cause       = link_enable & ~link_in_data_state;
  wire link_64b66b_cause      = link_startup | link_realign;
  wire link_state_alarm       = link_mode_64b66b ? link_64b66b_cause : link_8b10b_cause;
  wire clock_realign_alarm    = sysref_realign;
  wire oscillator_phase_alarm = ~link_enable | osc_sync | osc_phase_mismatch;
  wire divider_mismatch_alarm = divider_mismatch;

  wire [`CAA_NUM_FLAGS-1:0] flag_set = {lane_fifo_alarm, pll_lock_alarm, link_state_alarm,
                                        clock_realign_alarm, oscillator_phase_alarm,
                                        divider_mismatch_alarm};
  wire [`CAA_NUM_FLAGS-1:0] flag_clr =
    wr_status ? reg_wdata[`CAA_NUM_FLAGS-1:0] : '0;
  wire fifo_flag_clr = flag_clr[`CAA_BIT_FIFO];

  wire [15:0] lane_wr_bits = {reg_wdata, reg_wdata};
  wire [15:0] lane_wr_sel  = {{8{reg_wr & hit_lane_hi}}, {8{reg_wr & hit_lane_lo}}};
  wire [LANES-1:0] lane_clr =
    (lane_wr_bits[LANES-1:0] & lane_wr_sel[LANES-1:0]) | {LANES{fifo_flag_clr}};

  // hardware set wins over a same-cycle clear; preset on either reset
  caa_sticky_bank #(
    .WIDTH  (`CAA_NUM_FLAGS),
    .PRESET ({8'h00, `CAA_RST_STATUS})
  ) u_flags (
    .clk   (clk),
    .rst   (rst),
    .init  (soft_reset),
    .set   (flag_set),
    .clr   (flag_clr),
    .flags (alarm_flag_status)
  );

  caa_sticky_bank #(
    .WIDTH  (LANES),
    .PRESET (`CAA_RST_LANE)
  ) u_lanes (
    .clk   (clk),
    .rst   (rst),
    .init  (soft_reset),
    .set   (lane_fifo_err),
    .clr   (lane_clr),
    .flags (per_lane_overflow_alarm)
  );

  wire alarm_summary = |(alarm_flag_status & ~alarm_flag_mask_q[`CAA_NUM_FLAGS-1:0]);
  wire pin_d         = alarm_pin_sel ? alarm_summary : cal_status;

  wire [15:0] lane_padded = 16'(per_lane_overflow_alarm);
  wire caa_byte_t rd_mux =
    hit_summary ? {7'h00, alarm_summary} :
    hit_status  ? {status_rsvd_q, alarm_flag_status} :
    hit_mask    ? alarm_flag_mask_q :
    hit_lane_lo ? lane_padded[7:0] :
    hit_lane_hi ? lane_padded[15:8] : 8'h00;

  always_ff @(posedge clk)
  begin
    if (rst || soft_reset)
    begin
      alarm_flag_mask_q <= `CAA_RST_MASK;
      status_rsvd_q     <= 2'h0;
    end
    else
    begin
      if (wr_mask)
        alarm_flag_mask_q <= reg_wdata;
      if (wr_status)
        status_rsvd_q <= reg_wdata[7:6];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      pin_q    <= 1'b0;
    end
    else
    begin
      rdata_q  <= reg_rd ? rd_mux : rdata_q;
      rvalid_q <= reg_rd;
      pin_q    <= pin_d;
    end
  end

  assign reg_rdata              = rdata_q;
  assign reg_rvalid             = rvalid_q;
  assign calibration_status_pin = pin_q;

  // checks
  a_summary_follows_flags : assert property (@(posedge clk) disable iff (rst)
    reg_rd && hit_summary |=> reg_rdata[0] == $past(alarm_summary))
    else $error("summary read does not match flags");
  a_pin_routes_alarm : assert property (@(posedge clk) disable iff (rst)
    alarm_pin_sel |=> calibration_status_pin == $past(alarm_summary))
    else $error("status pin does not carry summary");
  a_fifo_flag_sets : assert property (@(posedge clk) disable iff (rst || soft_reset)
    |lane_fifo_err |=> alarm_flag_status[`CAA_BIT_FIFO])
    else $error("fifo flag not set");
  a_pll_flag_sets : assert property (@(posedge clk) disable iff (rst || soft_reset)
    !pll_locked |=> alarm_flag_status[`CAA_BIT_PLL])
    else $error("pll flag not set");
  a_link_8b10b_sets : assert property (@(posedge clk) disable iff (rst || soft_reset)
    !link_mode_64b66b && link_enable && !link_in_data_state |=> alarm_flag_status[3])
    else $error("link flag not set in 8b10b");
  a_link_64b66b_sets : assert property (@(posedge clk) disable iff (rst || soft_reset)
    link_mode_64b66b && (link_startup || link_realign) |=> alarm_flag_status[3])
    else $error("link flag not set in 64b66b");
  a_realign_sets : assert property (@(posedge clk) disable iff (rst || soft_reset)
    sysref_realign |=> alarm_flag_status[`CAA_BIT_REALIGN])
    else $error("realign flag not set");
  a_phase_sets : assert property (@(posedge clk) disable iff (rst || soft_reset)
    !link_enable || osc_sync || osc_phase_mismatch |=> alarm_flag_status[`CAA_BIT_NCO])
    else $error("phase flag not set");
  a_divider_sets : assert property (@(posedge clk) disable iff (rst || soft_reset)
    divider_mismatch |=> alarm_flag_status[`CAA_BIT_CLK])
    else $error("divider flag not set");
  a_clear_by_one : assert property (@(posedge clk) disable iff (rst || soft_reset)
    wr_status && reg_wdata[`CAA_BIT_CLK] && !divider_mismatch |=> !alarm_flag_status[0])
    else $error("write one did not clear");
  a_reset_presets : assert property (@(posedge clk)
    soft_reset |=> alarm_flag_status == 6'h3f && alarm_flag_mask_q == `CAA_RST_MASK)
    else $error("reset preset wrong");
  a_mask_blocks : assert property (@(posedge clk) disable iff (rst)
    (alarm_flag_mask_q[5:0] == 6'h3f) |-> !alarm_summary)
    else $error("masked flag reached summary");
  a_mask_all_quiets : assert property (@(posedge clk) disable iff (rst || soft_reset)
    wr_mask && reg_wdata[5:0] == 6'h3f |=> !alarm_summary)
    else $error("full mask left summary high");
  a_unmasked_raises : assert property (@(posedge clk) disable iff (rst || soft_reset)
    wr_mask && reg_wdata[5:0] == 6'h00 && (|alarm_flag_status) |=> alarm_summary)
    else $error("unmasked flag missing from summary");
  a_lane_clear_all : assert property (@(posedge clk) disable iff (rst || soft_reset)
    fifo_flag_clr && !(|lane_fifo_err) |=> per_lane_overflow_alarm == '0)
    else $error("lane bits not cleared");
  a_lane_bit_sets : assert property (@(posedge clk) disable iff (rst || soft_reset)
    lane_fifo_err[0] |=> per_lane_overflow_alarm[0])
    else $error("lane bit not set");
  a_flag_holds : assert property (@(posedge clk) disable iff (rst || soft_reset)
    alarm_flag_status[4] && !wr_status |=> alarm_flag_status[4])
    else $error("flag dropped without clear");

  c_summary_rise : cover property (@(posedge clk) disable iff (rst) $rose(alarm_summary));
  c_clear_all    : cover property (@(posedge clk) disable iff (rst)
    wr_status ##1 alarm_flag_status == '0);
  c_set_on_clear : cover property (@(posedge clk) disable iff (rst)
    wr_status && reg_wdata[4] && !pll_locked);
  c_pin_cal_path : cover property (@(posedge clk) disable iff (rst)
    !alarm_pin_sel && cal_status);
endmodule // caa_alarm_aggregator
`default_nettype wire

// ---- verilog/caa_defines.svh ----
// register offsets, field positions and reset values of the alarm aggregator
`ifndef CAA_DEFINES_SVH
`define CAA_DEFINES_SVH

`define CAA_ADDR_W          12
`define CAA_OFS_SUMMARY     12'h2c0
`define CAA_OFS_STATUS      12'h2c1
`define CAA_OFS_MASK        12'h2c2
`define CAA_OFS_LANE_LO     12'h2c4
`define CAA_OFS_LANE_HI     12'h2c5

`define CAA_NUM_FLAGS       6
`define CAA_BIT_FIFO        5
`define CAA_BIT_PLL         4
`define CAA_BIT_LINK        3
`define CAA_BIT_REALIGN     2
`define CAA_BIT_NCO         1
`define CAA_BIT_CLK         0
`define CAA_BIT_SUMMARY     0

`define CAA_RST_STATUS      8'h3f
`define CAA_RST_MASK        8'h3f
`define CAA_RST_LANE        16'hffff
`define CAA_RST_SUMMARY     8'h00

`endif

// ---- verilog/caa_pkg.sv ----
// shared types of the alarm aggregator
package caa_pkg;
  typedef logic [7:0]  caa_byte_t;
  typedef logic [11:0] caa_addr_t;
endpackage

// ---- verilog/caa_sticky_bank.sv ----
// bank of sticky flags: set wins over clear, loads a preset on init
`timescale 1ns/1ps
`default_nettype none
module caa_sticky_bank #(
  parameter int          WIDTH  = 6,
  parameter logic [15:0] PRESET = 16'hffff
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             init,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] flags
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic flag_q;
      wire  flag_d = set[i] | (flag_q & ~clr[i]);
      always_ff @(posedge clk)
      begin
        if (rst || init)
          flag_q <= PRESET[i];
        else
          flag_q <= flag_d;
      end
      assign flags[i] = flag_q;
    end
  endgenerate
endmodule // caa_sticky_bank
`default_nettype wire

// ---- sim/converter_alarm_aggregator_tb.sv ----
// self-checking bench of the alarm aggregator against a behavioural model
`timescale 1ns/1ps
`default_nettype none
`include "caa_defines.svh"
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e); end end
module converter_alarm_aggregator_tb
  import caa_pkg::*;
;
  logic        clk, rst, soft_reset, reg_wr, reg_rd, reg_rvalid, calibration_status_pin;
  caa_addr_t   reg_addr;
  caa_byte_t   reg_wdata, reg_rdata;
  logic [15:0] lane_fifo_err;
  logic        pll_locked, link_enable, link_mode_64b66b, link_in_data_state, link_startup;
  logic        link_realign, sysref_realign, osc_sync, osc_phase_mismatch, divider_mismatch;
  logic        alarm_pin_sel, cal_status;
  int          num_errors, checks_done, cycles, seed, m_flags, m_mask, m_res, m_lanes;
  int          m_rdata, m_rvalid, m_pin;

  caa_alarm_aggregator #(.LANES(16)) caa_alarm_aggregator_inst (.clk(clk), .rst(rst),
    .soft_reset(soft_reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .lane_fifo_err(lane_fifo_err), .pll_locked(pll_locked), .link_enable(link_enable),
    .link_mode_64b66b(link_mode_64b66b), .link_in_data_state(link_in_data_state),
    .link_startup(link_startup), .link_realign(link_realign), .sysref_realign(sysref_realign),
    .osc_sync(osc_sync), .osc_phase_mismatch(osc_phase_mismatch),
    .divider_mismatch(divider_mismatch), .alarm_pin_sel(alarm_pin_sel),
    .cal_status(cal_status), .calibration_status_pin(calibration_status_pin));

  // behavioural model, updated on the same edge as the design
  always @(posedge clk)
  begin : model
    int s, rd, sum;
    s = ((|lane_fifo_err) << 5) | (!pll_locked << 4) | (!link_enable || osc_sync || osc_phase_mismatch) << 1;
    s = s | (link_mode_64b66b ? (link_startup | link_realign) : (link_enable & !link_in_data_state)) << 3;
    s = s | (sysref_realign << 2) | divider_mismatch;
    sum = ((m_flags & ~m_mask & 'h3f) != 0);
    case (reg_addr)
      `CAA_OFS_SUMMARY: rd = sum;
      `CAA_OFS_STATUS:  rd = (m_res << 6) | m_flags;
      `CAA_OFS_MASK:    rd = m_mask;
      `CAA_OFS_LANE_LO: rd = m_lanes & 'hff;
      `CAA_OFS_LANE_HI: rd = m_lanes >> 8;
      default:          rd = 0;
    endcase
    if (rst)
    begin
      m_rdata = 0; m_rvalid = 0; m_pin = 0;
    end
    else
    begin
      m_rvalid = reg_rd;
      if (reg_rd) m_rdata = rd;
      m_pin = alarm_pin_sel ? sum : cal_status;
    end
    if (rst || soft_reset)
    begin
      m_flags = 'h3f; m_mask = 'h3f; m_res = 0; m_lanes = 'hffff;
    end
    else
    begin
      if (reg_wr && reg_addr == `CAA_OFS_STATUS)
      begin
        m_flags = m_flags & ~reg_wdata; m_res = reg_wdata >> 6;
        if (reg_wdata[5]) m_lanes = 0;
      end
      if (reg_wr && reg_addr == `CAA_OFS_MASK) m_mask = reg_wdata;
      if (reg_wr && reg_addr == `CAA_OFS_LANE_LO) m_lanes = m_lanes & ~reg_wdata;
      if (reg_wr && reg_addr == `CAA_OFS_LANE_HI) m_lanes = m_lanes & ~(reg_wdata << 8);
      m_flags = (m_flags | s) & 'h3f;
      m_lanes = m_lanes | lane_fifo_err;
    end
  end

  task automatic step(input logic wr, input logic rd, input caa_addr_t a, input caa_byte_t d);
    @(negedge clk);
    `CHK(reg_rvalid, m_rvalid[0], "read valid")
    `CHK(calibration_status_pin, m_pin[0], "status pin")
    `CHK(reg_rdata, caa_byte_t'(m_rdata), "read data")
    reg_wr = wr; reg_rd = rd; reg_addr = a; reg_wdata = d;
  endtask

  // every cause input assigned exactly once per call
  task automatic cause(input int k, input logic on);
    divider_mismatch   = on && k == 0;
    osc_phase_mismatch = on && k == 1;
    sysref_realign     = on && k == 2;
    link_in_data_state = !(on && k == 3);
    pll_locked         = !(on && k == 4);
    lane_fifo_err      = (on && k == 5) ? 16'h8001 : 16'h0000;
    link_mode_64b66b   = k == 6 || k == 7;
    link_startup       = on && k == 6;
    link_realign       = on && k == 7;
    osc_sync           = on && k == 8;
    link_enable        = !(on && k == 9);
    soft_reset         = on && k == 10;
  endtask

  task automatic quiet;
    cause(0, 1'b0);
  endtask

  task automatic read_all;
    for (int i = 0; i < 8; i++) step(0, 1, `CAA_OFS_SUMMARY + 12'(i), 8'h00);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("MISMATCH %0t run did not finish", $time);
      complete_run();
    end
  end

  initial
  begin : main
    logic [31:0] r, q;
    seed = 82650; rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 12'h2c0; reg_wdata = 8'h00;
    alarm_pin_sel = 1; cal_status = 0; quiet();
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 0;
    read_all();
    $display("test reset_values done");
    step(1, 0, `CAA_OFS_STATUS, 8'h3f);
    step(1, 1, `CAA_OFS_MASK, 8'h00);
    for (int k = 0; k < 10; k++)
    begin
      cause(k, 1);
      step(0, 1, `CAA_OFS_SUMMARY, 8'h00);
      cause(k, 0);
      step(0, 1, `CAA_OFS_STATUS, 8'h00);
      step(0, 1, `CAA_OFS_LANE_HI, 8'h00);
      step(1, 1, `CAA_OFS_STATUS, 8'hff);
      step(1, 1, `CAA_OFS_LANE_LO, 8'hff);
      step(0, 1, `CAA_OFS_STATUS, 8'h00);
    end
    cause(4, 1);
    step(1, 1, `CAA_OFS_MASK, 8'h3f);
    step(1, 1, `CAA_OFS_MASK, 8'h00);
    step(0, 1, `CAA_OFS_SUMMARY, 8'h00);
    $display("test alarm_sources done");
    for (int n = 0; n < 3000; n++)
    begin
      r = $random(seed); q = $random(seed);
      step(r[0] & !q[31], r[2], `CAA_OFS_SUMMARY + 12'(r[5:3]), r[13:6]);
      lane_fifo_err = (r[16:14] == 0) ? q[15:0] : 16'h0000;
      pll_locked = r[17] | r[18]; link_enable = r[19] | r[20]; link_mode_64b66b = r[21];
      link_in_data_state = r[22] | r[23]; link_startup = &r[26:24]; link_realign = &r[29:27];
      sysref_realign = &r[31:30] & q[16]; osc_sync = &q[19:17]; osc_phase_mismatch = &q[22:20];
      divider_mismatch = &q[25:23]; alarm_pin_sel = q[26]; cal_status = q[27];
      soft_reset = &q[31:27];
    end
    $display("test random_traffic done");
    step(0, 0, `CAA_OFS_SUMMARY, 8'h00);
    cause(10, 1);
    step(0, 0, `CAA_OFS_SUMMARY, 8'h00);
    cause(10, 0);
    read_all();
    step(0, 0, `CAA_OFS_SUMMARY, 8'h00);
    $display("test soft_reset done");
    complete_run();
  end
endmodule // converter_alarm_aggregator_tb
`default_nettype wire
